// File: include/dacwf_consts.svh
`ifndef DACWF_CONSTS_SVH
`define DACWF_CONSTS_SVH
// Notes on behaviour
// - First DAC mode 00 down/write both, 01 up/both, 10 up/input, 11 up/shift.
// - Second DAC mode field uses the same four encodings on the dual variant.
// - After reset all DACs and op amps are down with outputs released.
// - Op amp enable powers op amp one; bit 4 powers op amp two on the single variant only; both reset to 0.
// - Reference field sets buffer gain with reference off, voltage with it on.
// - Reference enable 1 turns on internal 2.5 V reference; 0 allows external.
// - Reference enable is one flop seen in DAC and ADC control registers.
// - Any write that changes the FIFO control register resets the sequence.
// - First step after a sequence reset copies input register to output.
// - Direct DAC writes during sequencing leave the sequence position alone.
// - FIFO data writes are ignored while the sequencer enable is 1.
// - Words added in phases 1 and 2; bipolar also subtracts in 3 and 4.
// - Symmetry 0 runs phase 1 or 1,4; symmetry 1 runs 1,2 or 1-4.
// - Continuous 0 makes one waveform; continuous 1 repeats it.
// - Sixteen words stored; sequencer uses only programmed depth.
// - Output is input plus word; first uses none, then location 1 upward.
// - All FIFO control fields reset to zero.
// - Reference codes 00 off, 01 0.5/1.25, 10 0.8192/2.048, 11 1.0/2.5.
// - Depth equals the four-bit field plus one, 1 to 16.
// - Step write is 8 address bits plus 8 ignored; step on 16th edge.
// - Bipolar words are sign-magnitude, 11 magnitude bits; else plain binary.

// Register addresses in the command byte (bit 7 selects a read)
`define DACWF_RD_BIT 7
`define DACWF_ADR_DAC_CTRL 7'h01
`define DACWF_ADR_ADC_CTRL 7'h02
`define DACWF_ADR_FIFO_CTRL 7'h03
`define DACWF_ADR_FIFO_DATA 7'h04
`define DACWF_ADR_SEQ_STEP 7'h05
`define DACWF_ADR_DAC_A 7'h06
`define DACWF_ADR_DAC_B 7'h07
// Frame edge counts
`define DACWF_CNT_ADDR 6'h08
`define DACWF_CNT_BYTE 6'h10
`define DACWF_CNT_WORD 6'h18
// Storage and reset values
`define DACWF_FIFO_WORDS 5'h10
`define DACWF_CTRL_RST 8'h00
`define DACWF_MAX_CODE 14'sh0FFF
`endif

// File: include/dacwf_pkg.sv
package dacwf_pkg;
    typedef struct packed {
        logic [1:0] first_dac_power_mode;
        logic [1:0] second_dac_power_mode;
        logic op_amp_one_enable;
        logic [1:0] ref_buffer_select;
        logic internal_ref_enable;
    } dacwf_dac_ctrl_type;
    typedef struct packed {
        logic sequencer_enable;
        logic waveform_bipolar;
        logic waveform_symmetric;
        logic waveform_continuous;
        logic [3:0] waveform_depth;
    } dacwf_fifo_ctrl_type;
    typedef struct packed {
        logic [1:0] dac_powered;
        logic [1:0] dac_out_oe;
        logic [1:0] op_amp_on;
        logic [1:0] ref_buffer_select;
        logic ref_buffer_on;
        logic internal_ref_enable;
    } dacwf_analog_type;
    typedef enum logic [1:0] {
        DACWF_PH1,
        DACWF_PH2,
        DACWF_PH3,
        DACWF_PH4
    } dacwf_phase_type;
endpackage

// File: verilog/dacwf_top.sv
`timescale 1ns/10ps
`include "dacwf_consts.svh"
module dacwf_top #(
    parameter bit DUAL_DAC = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial register port
    input wire logic ser_cs_n,
    input wire logic ser_sclk,
    input wire logic ser_sdi,
    output logic ser_sdo,
    output logic ser_sdo_oe,
    // Step strobes
    input wire logic dac_load_strobe_a,
    input wire logic dac_load_strobe_both,
    // Analog control
    output dacwf_pkg::dacwf_analog_type analog,
    output logic [6:0] adc_ctrl_upper,
    output logic [11:0] second_dac_word,
    // First DAC output stream
    output logic [11:0] first_dac_word,
    output logic first_dac_valid,
    input wire logic first_dac_ready
);
    import dacwf_pkg::*;

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    logic sclk_q;
    logic [5:0] cnt_q, cnt_d;
    logic [15:0] sh_q;
    logic [7:0] cmd_q;
    logic [15:0] osh_q, osh_d;
    logic [4:0] fptr_q, fptr_d;
    logic strobe_a_q, strobe_b_q;

    wire rise = ser_sclk & ~sclk_q & ~ser_cs_n;
    wire [5:0] cnt_n = cnt_q + 6'h01;
    wire [15:0] sh_n = {sh_q[14:0], ser_sdi};
    wire addr_done = rise && cnt_n == `DACWF_CNT_ADDR;
    wire byte_done = rise && cnt_n == `DACWF_CNT_BYTE;
    wire word_done = rise && cnt_n == `DACWF_CNT_WORD;
    wire [7:0] cmd_now = addr_done ? sh_n[7:0] : cmd_q;
    wire is_rd = cmd_now[`DACWF_RD_BIT];
    wire [6:0] adr = cmd_now[6:0];
    wire wr_dac_ctrl = byte_done && !is_rd && adr == `DACWF_ADR_DAC_CTRL;
    wire wr_adc_ctrl = byte_done && !is_rd && adr == `DACWF_ADR_ADC_CTRL;
    wire wr_fifo_ctrl = byte_done && !is_rd && adr == `DACWF_ADR_FIFO_CTRL;
    wire wr_seq = byte_done && !is_rd && adr == `DACWF_ADR_SEQ_STEP;
    wire wr_fifo = word_done && !is_rd && adr == `DACWF_ADR_FIFO_DATA;
    wire [1:0] wr_dac;
    assign wr_dac[0] = word_done && !is_rd && adr == `DACWF_ADR_DAC_A;
    assign wr_dac[1] = word_done && !is_rd && adr == `DACWF_ADR_DAC_B;
    wire [11:0] wdata = sh_n[15:4];
    // Byte registers take the second byte of the frame, not the command
    wire [7:0] wbyte = sh_n[7:0];

    // Words run back to back after the address byte
    assign cnt_d = ser_cs_n ? 6'h00 : (word_done ? `DACWF_CNT_ADDR : (rise ? cnt_n : cnt_q));
    assign fptr_d = addr_done ? 5'h00 : ((word_done && fptr_q != `DACWF_FIFO_WORDS) ? fptr_q + 5'h01 : fptr_q);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            cnt_q <= 6'h00;
            sh_q <= 16'h0000;
            cmd_q <= 8'h00;
            fptr_q <= 5'h00;
            strobe_a_q <= 1'b0;
            strobe_b_q <= 1'b0;
        end
        else
        begin
            sclk_q <= ser_sclk;
            cnt_q <= cnt_d;
            sh_q <= rise ? sh_n : sh_q;
            cmd_q <= cmd_now;
            fptr_q <= fptr_d;
            strobe_a_q <= dac_load_strobe_a;
            strobe_b_q <= dac_load_strobe_both;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    dacwf_dac_ctrl_type dctl_q;
    dacwf_fifo_ctrl_type fctl_q;
    logic [6:0] adc_up_q;
    logic [11:0] mem_q [16];
    logic [11:0] in_q [2];
    logic [11:0] out_q [2];

    wire internal_ref_enable_d = wr_dac_ctrl ? wbyte[0] : (wr_adc_ctrl ? wbyte[0] : dctl_q.internal_ref_enable);
    wire fctl_change = wr_fifo_ctrl && wbyte != fctl_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dctl_q <= `DACWF_CTRL_RST;
            fctl_q <= `DACWF_CTRL_RST;
            adc_up_q <= 7'h00;
        end
        else
        begin
            dctl_q <= wr_dac_ctrl ? {wbyte[7:1], internal_ref_enable_d} : {dctl_q[7:1], internal_ref_enable_d};
            fctl_q <= wr_fifo_ctrl ? wbyte : fctl_q;
            adc_up_q <= wr_adc_ctrl ? wbyte[7:1] : adc_up_q;
        end
    end

    // data writes ignored while enabled; no write past last location
    wire fifo_we = wr_fifo && !fctl_q.sequencer_enable && fptr_q != `DACWF_FIFO_WORDS;
    always_ff @(posedge ref_clk)
    begin
        if (fifo_we)
            mem_q[fptr_q[3:0]] <= wdata;
    end

    // ----------------------------------------
    // Analog decode
    // ----------------------------------------
    logic [1:0] mode [2];
    assign mode[0] = dctl_q.first_dac_power_mode;
    // second channel exists only on the dual variant
    assign mode[1] = DUAL_DAC ? dctl_q.second_dac_power_mode : 2'b00;
    // on the single variant bit 4 drives op amp two
    assign analog.op_amp_on = {~DUAL_DAC & dctl_q.second_dac_power_mode[0], dctl_q.op_amp_one_enable};
    // field passed as gain or voltage code by reference state
    assign analog.ref_buffer_select = dctl_q.ref_buffer_select;
    // code 00 turns the buffer off
    assign analog.ref_buffer_on = dctl_q.ref_buffer_select != 2'b00;
    assign analog.internal_ref_enable = dctl_q.internal_ref_enable;
    assign adc_ctrl_upper = adc_up_q;
    assign second_dac_word = out_q[1];

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    dacwf_phase_type ph_q, ph_d;
    logic [4:0] loc_q, loc_d;
    logic started_q, done_q, done_d, pend_q;
    logic buf_ready;
    logic out0_load;

    // last used location equals field plus one
    wire [4:0] last_loc = {1'b0, fctl_q.waveform_depth} + 5'h01;
    wire step_evt = fctl_q.sequencer_enable && (wr_seq || (dac_load_strobe_a & ~strobe_a_q)
        || (dac_load_strobe_both & ~strobe_b_q));
    // Steps wait while the output buffer is full so no word is dropped
    wire step_go = pend_q && buf_ready && !wr_dac[0];
    wire rising = ph_q == DACWF_PH1 || ph_q == DACWF_PH3;
    wire at_end = rising ? loc_q == last_loc : loc_q == 5'h00;

    // phase order by symmetry and polarity
    always_comb
    begin
        ph_d = ph_q;
        loc_d = loc_q;
        done_d = done_q;
        if (!started_q)
            loc_d = 5'h00;
        else if (!at_end)
            loc_d = rising ? loc_q + 5'h01 : loc_q - 5'h01;
        else
        begin
            unique case (ph_q)
                DACWF_PH1: ph_d = fctl_q.waveform_symmetric ? DACWF_PH2
                    : (fctl_q.waveform_bipolar ? DACWF_PH4 : DACWF_PH1);
                DACWF_PH2: ph_d = fctl_q.waveform_bipolar ? DACWF_PH3 : DACWF_PH1;
                DACWF_PH3: ph_d = DACWF_PH4;
                DACWF_PH4: ph_d = DACWF_PH1;
            endcase
            // falling phases walk back from the location before the last
            if (ph_d == DACWF_PH2 || ph_d == DACWF_PH4)
                loc_d = last_loc - 5'h01;
            else
                loc_d = rising ? 5'h00 : 5'h01;
            // single waveform stops at the wrap
            if (ph_d == DACWF_PH1 && !fctl_q.waveform_continuous)
            begin
                ph_d = ph_q;
                loc_d = loc_q;
                done_d = 1'b1;
            end
        end
    end

    // location zero adds nothing, locations up to depth add their word
    wire [11:0] word = loc_d == 5'h00 ? 12'h000 : mem_q[4'(loc_d - 5'h01)];
    // sign-magnitude when bipolar, plain binary otherwise
    wire signed [13:0] offs = fctl_q.waveform_bipolar
        ? (word[11] ? -$signed({3'b000, word[10:0]}) : $signed({3'b000, word[10:0]}))
        : $signed({2'b00, word});
    // subtract in phases 3 and 4
    wire sub_ph = ph_d == DACWF_PH3 || ph_d == DACWF_PH4;
    wire signed [13:0] sum = $signed({2'b00, in_q[0]}) + (sub_ph ? -offs : offs);
    wire [11:0] seq_val = sum < 0 ? 12'h000 : (sum > `DACWF_MAX_CODE ? 12'hFFF : sum[11:0]);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || fctl_change)
        begin
            ph_q <= DACWF_PH1;
            loc_q <= 5'h00;
            started_q <= 1'b0;
            done_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else if (step_go && !done_q)
        begin
            ph_q <= ph_d;
            loc_q <= loc_d;
            started_q <= 1'b1;
            done_q <= done_d;
            pend_q <= step_evt;
        end
        else
        begin
            // step request from the 16th edge held until the buffer lets it be taken
            pend_q <= (pend_q && !done_q) | step_evt;
        end
    end

    // ----------------------------------------
    // DAC input and output registers
    // ----------------------------------------
    // direct writes never touch the sequence state
    for (genvar c = 0; c < 2; c++)
    begin : g_dac
        wire ld_in = wr_dac[c] && mode[c] != 2'b11;
        wire ld_out = wr_dac[c] && mode[c][1] == 1'b0;
        wire shift = wr_dac[c] && mode[c] == 2'b11;
        wire seq_ld = c == 0 && step_go && !done_q && !done_d;
        always_ff @(posedge ref_clk)
        begin
            if (!rst_n)
            begin
                in_q[c] <= 12'h000;
                out_q[c] <= 12'h000;
            end
            else
            begin
                in_q[c] <= (ld_in | shift) ? wdata : in_q[c];
                // first step gives input value unchanged
                out_q[c] <= ld_out ? wdata : (shift ? in_q[c] : (seq_ld ? seq_val : out_q[c]));
            end
        end
        assign analog.dac_powered[c] = mode[c] != 2'b00;
        assign analog.dac_out_oe[c] = mode[c] != 2'b00;
    end
    // the step that would wrap a single waveform emits no word
    assign out0_load = (wr_dac[0] && mode[0] != 2'b10) || (step_go && !done_q && !done_d);

    // ----------------------------------------
    // Two-entry output buffer
    // ----------------------------------------
    logic [11:0] buf_q [2];
    logic [1:0] cnt_buf_q;
    logic load_pend_q;
    wire pop = first_dac_valid && first_dac_ready;
    wire push = load_pend_q && (cnt_buf_q != 2'h2 || pop);
    assign buf_ready = cnt_buf_q == 2'h0 || (cnt_buf_q == 2'h1 && !load_pend_q);
    assign first_dac_valid = cnt_buf_q != 2'h0;
    assign first_dac_word = buf_q[0];
    wire [1:0] cnt_buf_d = cnt_buf_q + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt_buf_q <= 2'h0;
            load_pend_q <= 1'b0;
            buf_q[0] <= 12'h000;
            buf_q[1] <= 12'h000;
        end
        else
        begin
            cnt_buf_q <= cnt_buf_d;
            load_pend_q <= out0_load | (load_pend_q & ~push);
            if (pop)
                buf_q[0] <= (cnt_buf_q == 2'h2) ? buf_q[1] : out_q[0];
            else if (push && cnt_buf_q == 2'h0)
                buf_q[0] <= out_q[0];
            if (push && cnt_buf_d == 2'h2)
                buf_q[1] <= out_q[0];
        end
    end

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    logic [7:0] rd_byte;
    assign rd_byte = adr == `DACWF_ADR_DAC_CTRL ? dctl_q : (adr == `DACWF_ADR_ADC_CTRL
        ? {adc_up_q, dctl_q.internal_ref_enable} : (adr == `DACWF_ADR_FIFO_CTRL ? fctl_q : 8'h00));
    wire [4:0] rptr = addr_done ? 5'h00 : fptr_q + 5'h01;
    wire [11:0] rd_word = adr == `DACWF_ADR_DAC_A ? in_q[0] : (adr == `DACWF_ADR_DAC_B ? in_q[1]
        : (adr == `DACWF_ADR_FIFO_DATA && rptr < `DACWF_FIFO_WORDS ? mem_q[rptr[3:0]] : {rd_byte, 4'h0}));
    assign osh_d = ((addr_done || word_done) && is_rd) ? {rd_word, 4'h0} : (rise ? {osh_q[14:0], 1'b0} : osh_q);
    assign ser_sdo = osh_q[15];
    assign ser_sdo_oe = !ser_cs_n && cmd_q[`DACWF_RD_BIT] && cnt_q >= `DACWF_CNT_ADDR;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            osh_q <= 16'h0000;
        else
            osh_q <= osh_d;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_internal_ref_enable_shared;
        wr_adc_ctrl |=> analog.internal_ref_enable == $past(wbyte[0]);
    endproperty
    a_internal_ref_enable_shared: assert property (p_internal_ref_enable_shared) else $error("Reference bit not shared");
    property p_fifo_locked;
        (wr_fifo && fctl_q.sequencer_enable) |=> mem_q[$past(fptr_q[3:0])] == $past(mem_q[fptr_q[3:0]]);
    endproperty
    a_fifo_locked: assert property (p_fifo_locked) else $error("FIFO written while enabled");
    property p_ctrl_restart;
        fctl_change |=> !started_q && loc_q == 5'h00 && ph_q == DACWF_PH1;
    endproperty
    a_ctrl_restart: assert property (p_ctrl_restart) else $error("Sequence not restarted");
    property p_first_copy;
        (step_go && !started_q && !done_q) |=> out_q[0] == in_q[0];
    endproperty
    a_first_copy: assert property (p_first_copy) else $error("First step not input value");
    property p_power_down_release;
        mode[0] == 2'b00 |-> !analog.dac_out_oe[0] && !analog.dac_powered[0];
    endproperty
    a_power_down_release: assert property (p_power_down_release) else $error("Down DAC drives");
    property p_depth_bound;
        loc_q <= last_loc;
    endproperty
    a_depth_bound: assert property (p_depth_bound) else $error("Location past depth");
    property p_done_hold;
        (done_q && !fctl_change && !wr_dac[0]) |=> $stable(out_q[0]);
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("Finished waveform moved");
    property p_step_edge;
        (wr_seq && fctl_q.sequencer_enable) |=> pend_q || started_q;
    endproperty
    a_step_edge: assert property (p_step_edge) else $error("Step write lost");
    property p_direct_keeps_seq;
        (wr_dac[0] && !fctl_change) |=> $stable(loc_q) && $stable(ph_q);
    endproperty
    a_direct_keeps_seq: assert property (p_direct_keeps_seq) else $error("Direct write moved sequence");
    property p_buf_stall;
        cnt_buf_q == 2'h2 && !pop |=> cnt_buf_q == 2'h2;
    endproperty
    a_buf_stall: assert property (p_buf_stall) else $error("Buffer lost a word");

    c_full_wave: cover property (done_q ##1 fctl_q.waveform_bipolar);
    c_phase_four: cover property (ph_q == DACWF_PH3 ##[1:40] ph_q == DACWF_PH4);
    c_buf_full: cover property (cnt_buf_q == 2'h2 && pend_q);
endmodule

// File: dv/dacwf_host_model.sv
`timescale 1ns/10ps
module dacwf_host_model (
    // Clock
    input wire logic ref_clk,
    // Serial register port
    output logic ser_cs_n,
    output logic ser_sclk,
    output logic ser_sdi,
    input wire logic ser_sdo
);
    initial
    begin
        ser_cs_n = 1'b1;
        ser_sclk = 1'b0;
        ser_sdi = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame: command byte, then words MSB first
    // ------------------------------------------------------------
    // The last word may be cut short, so byte registers and step writes share this task
    // address byte then data
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wq[$], input int last_bits,
                         output logic [15:0] rd);
        logic [15:0] sh;
        int n;
        rd = 16'h0000;
        @(posedge ref_clk);
        ser_cs_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int i = -1; i < wq.size(); i++)
        begin
            sh = (i < 0) ? {cmd, 8'h00} : wq[i];
            n = (i < 0) ? 8 : ((i == wq.size() - 1) ? last_bits : 16);
            for (int b = 0; b < n; b++)
            begin
                @(posedge ref_clk);
                ser_sdi <= sh[15 - b];
                ser_sclk <= 1'b0;
                @(posedge ref_clk);
                #1;
                if (i == 0)
                    rd[15 - b] = ser_sdo;
                @(posedge ref_clk);
                ser_sclk <= 1'b1;
                @(posedge ref_clk);
            end
        end
        @(posedge ref_clk);
        ser_sclk <= 1'b0;
        // Idle data line must not keep showing the last bit
        ser_sdi <= ~ser_sdi;
        @(posedge ref_clk);
        ser_cs_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/10ps
`include "dacwf_consts.svh"
module testbench;
    import dacwf_pkg::*;
    localparam int DEPTH = 3;
    localparam int NSTEPS = 14;
    logic ref_clk, rst_n, ser_cs_n, ser_sclk, ser_sdi, ser_sdo, ser_sdo_oe;
    logic dac_load_strobe_a, dac_load_strobe_both, first_dac_valid, first_dac_ready, stall;
    dacwf_analog_type analog;
    logic [6:0] adc_ctrl_upper;
    logic [11:0] second_dac_word, first_dac_word, x, in_a, out_a, in_b, out_b;
    logic [11:0] exp_q[$];
    logic [11:0] fifo_w[16];
    logic [15:0] rd;
    logic [15:0] wq[$];
    integer seed = 37;
    int err_count, num_checks, v;

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    dacwf_top #(.DUAL_DAC(1'b1)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ser_cs_n(ser_cs_n),
        .ser_sclk(ser_sclk), .ser_sdi(ser_sdi), .ser_sdo(ser_sdo), .ser_sdo_oe(ser_sdo_oe),
        .dac_load_strobe_a(dac_load_strobe_a), .dac_load_strobe_both(dac_load_strobe_both),
        .analog(analog), .adc_ctrl_upper(adc_ctrl_upper), .second_dac_word(second_dac_word),
        .first_dac_word(first_dac_word), .first_dac_valid(first_dac_valid),
        .first_dac_ready(first_dac_ready));
    dacwf_host_model u_host (.ref_clk(ref_clk), .ser_cs_n(ser_cs_n), .ser_sclk(ser_sclk),
        .ser_sdi(ser_sdi), .ser_sdo(ser_sdo));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic xfer(input logic [7:0] cmd, input logic [15:0] w, input int n);
        logic [15:0] q[$];
        q.push_back(w);
        u_host.frame(cmd, q, n, rd);
    endtask

    task automatic drain();
        int t;
        for (t = 0; t < 2000 && exp_q.size() > 0; t++)
            @(negedge ref_clk);
        if (exp_q.size() > 0)
        begin
            $display("ERROR stream expected %0d more words seen none", exp_q.size());
            err_count++;
            close_out();
        end
    endtask

    // Serial step write or one of the two strobes
    task automatic step(input int kind);
        logic [15:0] dc;
        dc = $random(seed);
        if (kind == 0)
            xfer({1'b0, `DACWF_ADR_SEQ_STEP}, {dc[7:0], 8'h00}, 8);
        else
        begin
            @(posedge ref_clk);
            dac_load_strobe_a <= (kind == 1);
            dac_load_strobe_both <= (kind == 2);
            repeat (2) @(posedge ref_clk);
            dac_load_strobe_a <= 1'b0;
            dac_load_strobe_both <= 1'b0;
        end
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // Signed location: negative subtracts, zero is the bare input value
    function automatic logic [11:0] val(int loc, int vin, bit bip);
        logic [11:0] w;
        int m, r;
        w = (loc == 0) ? 12'h000 : fifo_w[(loc < 0 ? -loc : loc) - 1];
        m = bip ? (w[11] ? -int'(w[10:0]) : int'(w[10:0])) : int'(w);
        r = (loc < 0) ? vin - m : vin + m;
        return (r < 0) ? 12'h000 : ((r > 4095) ? 12'hFFF : r[11:0]);
    endfunction

    task automatic run_seq(input logic [2:0] mode);
        int per[$], pts[$];
        int k, lim;
        for (k = 1; k <= DEPTH; k++) per.push_back(k);
        if (mode[1]) for (k = DEPTH - 1; k >= 0; k--) per.push_back(k);
        if (mode[2] && mode[1]) for (k = 1; k <= DEPTH; k++) per.push_back(-k);
        if (mode[2]) for (k = DEPTH - 1; k >= 0; k--) per.push_back(-k);
        pts.push_back(0);
        repeat (5)
        begin
            if (pts[$] != 0) pts.push_back(0);
            pts = {pts, per};
        end
        lim = mode[0] ? pts.size() : per.size() + 1;
        xfer({1'b0, `DACWF_ADR_FIFO_CTRL}, {1'b1, mode, 4'(DEPTH - 1), 8'h00}, 8);
        for (k = 0; k < NSTEPS; k++)
        begin
            stall <= (mode == 3'h3) && (k < 3);
            if (mode == 3'h7 && k == 5)
            begin
                v = 1024 + ($random(seed) & 12'h3FF);
                xfer({1'b0, `DACWF_ADR_DAC_A}, {v[11:0], 4'h0}, 16);
            end
            if (k < lim) exp_q.push_back(val(pts[k], v, mode[2]));
            step((mode == 3'h3 && k < 3) ? 1 : int'({$random(seed)} % 3));
            if (mode == 3'h3 && k == 2)
            begin
                check("stalled valid", 16'h0001, first_dac_valid);
                check("stalled head", val(0, v, 1'b0), first_dac_word);
                // Let the full buffer drain so the next step is not merged into the pending one
                stall <= 1'b0;
                repeat (12) @(posedge ref_clk);
                @(negedge ref_clk);
            end
        end
        drain();
    endtask

    // ------------------------------------------------------------
    // Stream watcher and consumer
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (rst_n && first_dac_valid === 1'b1 && first_dac_ready)
        begin
            if (exp_q.size() == 0)
                check("unexpected first_dac_word", 16'hFFFF, first_dac_word);
            else
                check("first_dac_word", exp_q.pop_front(), first_dac_word);
        end
        first_dac_ready <= !stall && ($random(seed) % 4 != 0);
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        dac_load_strobe_a = 1'b0;
        dac_load_strobe_both = 1'b0;
        first_dac_ready = 1'b0;
        stall = 1'b0;
        in_a = 12'h000;
        out_a = 12'h000;
        in_b = 12'h000;
        out_b = 12'h000;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check("analog", 16'h0000, analog);
        check("valid", 16'h0000, first_dac_valid);
        fork
            xfer({1'b1, `DACWF_ADR_FIFO_CTRL}, 16'h0000, 16);
            begin
                repeat (40) @(negedge ref_clk);
                check("sdo enable", 16'h0001, ser_sdo_oe);
            end
        join
        check("fifo ctrl", 16'h0000, rd);
        check("sdo enable idle", 16'h0000, ser_sdo_oe);
        xfer({1'b1, `DACWF_ADR_DAC_CTRL}, 16'h0000, 16);
        check("dac ctrl", 16'h0000, rd);
        xfer(8'hFF, 16'h0000, 16);
        check("unmapped", 16'h0000, rd);
        for (int r = 0; r < 8; r++)
        begin
            xfer({1'b0, `DACWF_ADR_DAC_CTRL}, {4'h0, r[0], r[1:0], r[2], 8'h00}, 8);
            check("ref select", 16'(r[1:0]), analog.ref_buffer_select);
            check("ref on", 16'(r[1:0] != 0), analog.ref_buffer_on);
            check("ref enable", 16'(r[2]), analog.internal_ref_enable);
            check("op amp", 16'(r[0]), analog.op_amp_on[0]);
            xfer({1'b1, `DACWF_ADR_ADC_CTRL}, 16'h0000, 16);
            check("adc ref mirror", 16'(r[2]), rd[8]);
        end
        xfer({1'b0, `DACWF_ADR_ADC_CTRL}, 16'hA400, 8);
        check("adc ctrl upper", 16'h0052, adc_ctrl_upper);
        xfer({1'b1, `DACWF_ADR_DAC_CTRL}, 16'h0000, 16);
        check("dac ctrl mirror", 16'h000E, rd[15:8]);
        for (int m = 0; m < 4; m++)
        begin
            xfer({1'b0, `DACWF_ADR_DAC_CTRL}, {m[1:0], m[1:0], 12'h000}, 8);
            x = $random(seed);
            if (m == 3) out_a = in_a;
            else if (m != 2) out_a = x;
            if (m != 2) exp_q.push_back(out_a);
            in_a = x;
            xfer({1'b0, `DACWF_ADR_DAC_A}, {x, 4'h0}, 16);
            x = $random(seed);
            if (m == 3) out_b = in_b;
            else if (m != 2) out_b = x;
            in_b = x;
            xfer({1'b0, `DACWF_ADR_DAC_B}, {x, 4'h0}, 16);
            check("second_dac_word", out_b, second_dac_word);
            check("powered", {14'h0000, {2{m != 0}}}, analog.dac_powered);
            check("out enable", {14'h0000, {2{m != 0}}}, analog.dac_out_oe);
            drain();
        end
        v = 1024 + ($random(seed) & 12'h7FF);
        xfer({1'b0, `DACWF_ADR_DAC_CTRL}, 16'h4000, 8);
        exp_q.push_back(v[11:0]);
        xfer({1'b0, `DACWF_ADR_DAC_A}, {v[11:0], 4'h0}, 16);
        xfer({1'b0, `DACWF_ADR_DAC_CTRL}, 16'h8000, 8);
        drain();
        // Host keeps the sequencer off while loading words
        xfer({1'b0, `DACWF_ADR_FIFO_CTRL}, 16'h0000, 8);
        for (int i = 0; i < 16; i++)
        begin
            fifo_w[i] = $random(seed) & 12'h8FF;
            wq.push_back({fifo_w[i], 4'h0});
        end
        u_host.frame({1'b0, `DACWF_ADR_FIFO_DATA}, wq, 16, rd);
        for (int md = 0; md < 8; md++)
            run_seq(md[2:0]);
        // Sequencer is on, so these words must be dropped
        foreach (wq[i]) wq[i] = ~wq[i];
        u_host.frame({1'b0, `DACWF_ADR_FIFO_DATA}, wq, 16, rd);
        run_seq(3'h6);
        close_out();
    end
endmodule
